// [verilog/gpio_pin_pkg.sv]
// Constants for the per-pin control block: register map, field layout, reset values.
// Assumes a 32-bit AXI4-Lite register bus and one pad per block.
package gpio_pin_pkg;

    // =====================================================================
    // Register map
    localparam logic [3:0] PAD_CONFIG_WORD_ADDR = 4'h0;
    localparam logic [3:0] PAD_CONTROL_ADDR     = 4'h4;

    // =====================================================================
    // Field positions
    localparam int PULL_LSB      = 0;
    localparam int SENSE_LSB     = 4;
    localparam int EDGE_EN_BIT   = 7;
    localparam int OPEN_DRAIN_BIT = 8;
    localparam int DIR_BIT       = 9;
    localparam int POLARITY_BIT  = 11;
    localparam int FUNC_LSB      = 12;
    localparam int ALT_DATA_BIT  = 16;
    localparam int ALT_WE_BIT    = 17;
    localparam int PAD_IN_BIT    = 24;
    localparam int WAKE_LATCH_BIT = 0;

    // Writable bits of the control word (reserved bits excluded)
    localparam logic [31:0] CONFIG_WRITE_MASK = 32'h0003_3bf3;
    localparam logic [31:0] CONFIG_RESET      = 32'h0000_0000;

    // =====================================================================
    // Encodings
    localparam logic [1:0] PULL_UP   = 2'h1;
    localparam logic [1:0] PULL_DOWN = 2'h2;
    localparam logic [2:0] SENSE_LOW     = 3'h0;
    localparam logic [2:0] SENSE_HIGH    = 3'h1;
    localparam logic [2:0] SENSE_RISE    = 3'h5;
    localparam logic [2:0] SENSE_FALL    = 3'h6;
    localparam logic [2:0] SENSE_EITHER  = 3'h7;
    localparam logic [1:0] FUNC_GPIO = 2'h0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : gpio_pin_pkg

// [verilog/pin_event_detect.sv]
// Interrupt detection for one pin: level or edge sense with optional inversion.
// Assumes the pad input is already synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module pin_event_detect (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       clkEn,
    input  wire logic       padIn,
    input  wire logic [2:0] sense,
    input  wire logic       edgeEnable,
    input  wire logic       invertSense,
    output var  logic       irqLevel,
    output var  logic       edgeEvent
);
    // =====================================================================
    // Sense evaluation
    logic prevIn;
    wire  senseIn  = padIn ^ invertSense;
    wire  prevSens = prevIn ^ invertSense;
    wire  rise     = senseIn & ~prevSens;
    wire  fall     = ~senseIn & prevSens;
    wire  isEdge   = sense[2] & (sense[1] | sense[0]);
    logic next_edgeEvent;

    always_comb begin
        case (sense)
            gpio_pin_pkg::SENSE_RISE:   next_edgeEvent = rise;
            gpio_pin_pkg::SENSE_FALL:   next_edgeEvent = fall;
            gpio_pin_pkg::SENSE_EITHER: next_edgeEvent = rise | fall;
            default:                    next_edgeEvent = 1'b0;
        endcase
        next_edgeEvent = next_edgeEvent & edgeEnable;  // [R4]
    end

    wire next_level = (sense == gpio_pin_pkg::SENSE_LOW)  ? ~senseIn :
                      (sense == gpio_pin_pkg::SENSE_HIGH) ?  senseIn : 1'b0;  // [R2] [R9]

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prevIn    <= 1'b0;
            irqLevel  <= 1'b0;
            edgeEvent <= 1'b0;
        end else if (clkEn) begin
            prevIn    <= padIn;
            irqLevel  <= next_level | (isEdge & next_edgeEvent);
            edgeEvent <= next_edgeEvent;
        end
    end

    chk_edge_gated: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn && !edgeEnable |=> !edgeEvent) else $error("edge event while disabled"); // [R4]
endmodule : pin_event_detect
`default_nettype wire

// [verilog/gpio_pin_control.sv]
// What this block does
// R1: Pull field 01 pulls up, 10 pulls down, 00 and 11 no pull.
// R2: Sense field: 000 low, 001 high, 101 rise, 110 fall, 111 either.
// R3: Wake only on edge code, edge enabled and aggregator enable all set.
// R4: Edge enable bit 7 gates edge detection and wake.
// R5: Software lowest power: edge disabled with edge code.
// R6: Bit 8 picks push-pull or open-drain for every function.
// R7: Direction bit 9 acts only while GPIO function selected.
// R8: Alternate function drives direction whenever function select nonzero.
// R9: Polarity inverts alternate outputs and interrupt sense; the code inverts interrupt sense only while an alternate function is selected.
// R10: Polarity has no effect on GPIO output.
// R11: Pad state read by software is never inverted.
// R12: Function select 13:12 routes GPIO or one of three alternates.
// R13: Bit 16 loads output latch only when bit 17 written set.
// R14: Bit 16 reads back the value last programmed.
// R15: Bit 24 reads current pad input, read-only.
// R16: Watchdog reset clears most words; designated pins use system reset only.
// R17: Reserved bits read zero, writes ignored.
//
// Per-pin GPIO control with AXI4-Lite register access.
// Assumes pad, alternate logic and aggregator are synchronous to sys_clk.
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_control #(
    parameter bit SYSTEM_RESET_ONLY = 1'b0
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        watchdogDrivenReset,
    input  wire logic        clkEn,
    // AXI4-Lite slave
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Pad
    input  wire logic        padIn,
    output var  logic        padOut,
    output var  logic        padOe,
    output var  logic        pullUpEn,
    output var  logic        pullDownEn,
    // Alternate functions 1..3
    input  wire logic [2:0]  altOut,
    input  wire logic [2:0]  altOe,
    output var  logic        altIn,
    // Aggregator and clock wake
    input  wire logic        aggIrqEnable,
    input  wire logic        ringStopped,
    output var  logic        pinIrq,
    output var  logic        ringWake
);
    // =====================================================================
    // Control word storage
    logic [31:0] configWord;
    logic        outLatch;

    wire [1:0] pullSelect  = configWord[gpio_pin_pkg::PULL_LSB +: 2];
    wire [2:0] sense       = configWord[gpio_pin_pkg::SENSE_LSB +: 3];
    wire       edgeEnable  = configWord[gpio_pin_pkg::EDGE_EN_BIT];
    wire       openDrain   = configWord[gpio_pin_pkg::OPEN_DRAIN_BIT];
    wire       dirOut      = configWord[gpio_pin_pkg::DIR_BIT];
    wire       polarity    = configWord[gpio_pin_pkg::POLARITY_BIT];
    wire [1:0] funcSelect  = configWord[gpio_pin_pkg::FUNC_LSB +: 2];
    wire       isGpio      = (funcSelect == gpio_pin_pkg::FUNC_GPIO);
    wire       invertAlt   = polarity & ~isGpio;  // [R9] [R10]

    // Reset source for this word
    wire wordReset = SYSTEM_RESET_ONLY ? rst : (rst | watchdogDrivenReset);  // [R16]

    // =====================================================================
    // AXI4-Lite write channel
    logic        awHeld;
    logic        wHeld;
    logic [3:0]  awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;

    wire awTake    = s_axi_awvalid & s_axi_awready;
    wire wTake     = s_axi_wvalid & s_axi_wready;
    wire doWrite   = awHeld & wHeld & ~s_axi_bvalid;
    wire wrHitCfg  = (awAddr == gpio_pin_pkg::PAD_CONFIG_WORD_ADDR);
    wire wrHitCtl  = (awAddr == gpio_pin_pkg::PAD_CONTROL_ADDR);

    function automatic logic [31:0] strbMask(input logic [3:0] s);
        strbMask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : strbMask

    wire [31:0] wMask   = strbMask(wStrb) & gpio_pin_pkg::CONFIG_WRITE_MASK;  // [R17]
    wire [31:0] next_configWord = (configWord & ~wMask) | (wData & wMask);
    wire        altLoad = doWrite & wrHitCfg & wStrb[2]
                        & wData[gpio_pin_pkg::ALT_WE_BIT];  // [R13]

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            awHeld        <= 1'b0;
            wHeld         <= 1'b0;
            awAddr        <= 4'h0;
            wData         <= 32'h0000_0000;
            wStrb         <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= gpio_pin_pkg::RESP_OKAY;
        end else if (clkEn) begin
            s_axi_awready <= ~awHeld & ~awTake & ~s_axi_awready;
            s_axi_wready  <= ~wHeld & ~wTake & ~s_axi_wready;
            if (awTake) begin
                awHeld <= 1'b1;
                awAddr <= {s_axi_awaddr[3:2], 2'h0};
            end
            if (wTake) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld       <= 1'b0;
                wHeld        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wrHitCfg | wrHitCtl) ? gpio_pin_pkg::RESP_OKAY
                                                      : gpio_pin_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // =====================================================================
    // Control word and output latch
    always_ff @(posedge sys_clk) begin
        if (wordReset) begin
            configWord <= gpio_pin_pkg::CONFIG_RESET;
            outLatch   <= 1'b0;
        end else if (clkEn) begin
            if (doWrite && wrHitCfg) begin
                configWord <= next_configWord;  // [R14] [R17]
            end
            if (altLoad) begin
                outLatch <= wData[gpio_pin_pkg::ALT_DATA_BIT];  // [R13]
            end
        end
    end

    // =====================================================================
    // Event detection and ring wake
    logic irqLevel;
    logic edgeEvent;
    logic wakeLatch;

    pin_event_detect eventDetect (
        .sys_clk     (sys_clk),
        .rst         (wordReset),
        .clkEn       (clkEn),
        .padIn       (padIn),
        .sense       (sense),
        .edgeEnable  (edgeEnable),
        .invertSense (invertAlt),
        .irqLevel    (irqLevel),
        .edgeEvent   (edgeEvent)
    );

    wire wakeCause = edgeEvent & aggIrqEnable & ringStopped;  // [R3] [R4]
    wire wakeClear = doWrite & wrHitCtl & wStrb[0] & wData[gpio_pin_pkg::WAKE_LATCH_BIT];

    // =====================================================================
    // AXI4-Lite read channel
    wire [31:0] cfgRead = (configWord & gpio_pin_pkg::CONFIG_WRITE_MASK & ~32'h0002_0000)
                        | (32'(padIn) << gpio_pin_pkg::PAD_IN_BIT);  // [R11] [R15] [R17]
    wire        rdHitCfg = (s_axi_araddr[3:2] == gpio_pin_pkg::PAD_CONFIG_WORD_ADDR[3:2]);
    wire        rdHitCtl = (s_axi_araddr[3:2] == gpio_pin_pkg::PAD_CONTROL_ADDR[3:2]);
    wire        arTake   = s_axi_arvalid & s_axi_arready;
    wire [31:0] rdData   = rdHitCfg ? cfgRead :
                           rdHitCtl ? {31'h0, wakeLatch} : 32'h0000_0000;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= gpio_pin_pkg::RESP_OKAY;
        end else if (clkEn) begin
            s_axi_arready <= ~s_axi_rvalid & ~arTake & ~s_axi_arready;
            if (arTake) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rdData;
                s_axi_rresp  <= (rdHitCfg | rdHitCtl) ? gpio_pin_pkg::RESP_OKAY
                                                      : gpio_pin_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // =====================================================================
    // Pad drive
    wire       altSelOut = altOut[funcSelect - 2'h1];
    wire       altSelOe  = altOe[funcSelect - 2'h1];
    wire       rawOut    = isGpio ? outLatch : (altSelOut ^ polarity);  // [R9] [R10] [R12]
    wire       rawOe     = isGpio ? dirOut : altSelOe;                   // [R7] [R8]
    wire       next_padOe  = rawOe & (~openDrain | ~rawOut);             // [R6]
    wire       next_padOut = openDrain ? 1'b0 : rawOut;                  // [R6]

    always_ff @(posedge sys_clk) begin
        if (wordReset) begin
            padOut     <= 1'b0;
            padOe      <= 1'b0;
            pullUpEn   <= 1'b0;
            pullDownEn <= 1'b0;
            altIn      <= 1'b0;
            pinIrq     <= 1'b0;
            ringWake   <= 1'b0;
            wakeLatch  <= 1'b0;
        end else if (clkEn) begin
            padOut     <= next_padOut;
            padOe      <= next_padOe;
            pullUpEn   <= (pullSelect == gpio_pin_pkg::PULL_UP);    // [R1]
            pullDownEn <= (pullSelect == gpio_pin_pkg::PULL_DOWN);  // [R1]
            altIn      <= isGpio ? 1'b0 : (padIn ^ polarity);       // [R9]
            pinIrq     <= irqLevel;                                  // [R2]
            ringWake   <= wakeCause;                                 // [R3]
            if (wakeCause) begin
                wakeLatch <= 1'b1;
            end else if (wakeClear) begin
                wakeLatch <= 1'b0;
            end
        end
    end

    // =====================================================================
    // Checks
    chk_pull_decode: assert property (@(posedge sys_clk) disable iff (wordReset)
        clkEn && pullSelect == 2'h3 |=> !pullUpEn && !pullDownEn)
        else $error("pull enabled for code 11"); // [R1]
    chk_level_no_wake: assert property (@(posedge sys_clk) disable iff (wordReset)
        clkEn && !sense[2] ##1 clkEn |=> !ringWake)
        else $error("wake from level sense"); // [R3]
    chk_wake_needs_agg: assert property (@(posedge sys_clk) disable iff (wordReset)
        ringWake && $past(clkEn) && $past(clkEn, 2)
        |-> $past(aggIrqEnable) && $past(edgeEnable, 2))
        else $error("wake without enables"); // [R4]
    chk_od_no_high: assert property (@(posedge sys_clk) disable iff (wordReset)
        padOe && $past(openDrain) && $past(clkEn) |-> !padOut)
        else $error("open drain drove high"); // [R6]
    chk_gpio_direction: assert property (@(posedge sys_clk) disable iff (wordReset)
        clkEn && isGpio |=> padOe == ($past(dirOut) & ~($past(openDrain) & $past(outLatch))))
        else $error("gpio direction wrong"); // [R7]
    chk_gpio_no_invert: assert property (@(posedge sys_clk) disable iff (wordReset)
        clkEn && isGpio && !openDrain |=> padOut == $past(outLatch))
        else $error("gpio output inverted"); // [R10]
    chk_alt_latch: assert property (@(posedge sys_clk) disable iff (wordReset)
        clkEn && doWrite && wrHitCfg && !wData[17] |=> $stable(outLatch))
        else $error("latch changed without enable"); // [R13]
    chk_pad_read: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn && arTake && rdHitCfg |=> s_axi_rdata[24] == $past(padIn))
        else $error("pad read mismatch"); // [R15]
    chk_reserved_zero: assert property (@(posedge sys_clk) disable iff (rst)
        s_axi_rvalid |-> (s_axi_rdata & 32'hfefc_c40c) == 32'h0000_0000)
        else $error("reserved bit read nonzero"); // [R17]

endmodule : gpio_pin_control
`default_nettype wire

// [tb/pad_far_side.sv]
// Far-side model of the pad wire: pin drive, pulls and an external driver.
// Assumes registered pad controls from the pin block on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module pad_far_side (
    input  wire logic sys_clk,
    input  wire logic padOut,
    input  wire logic padOe,
    input  wire logic pullUpEn,
    input  wire logic pullDownEn,
    input  wire logic extDrive,
    input  wire logic extLevel,
    output var  logic padIn
);
    logic floatBit = 1'b0;

    // An undriven, unpulled pad wanders every cycle
    always @(posedge sys_clk) floatBit <= ~floatBit;

    always_comb begin
        if (padOe) padIn = padOut;
        else if (extDrive) padIn = extLevel;
        else if (pullUpEn) padIn = 1'b1;
        else if (pullDownEn) padIn = 1'b0;
        else padIn = floatBit;
    end
endmodule : pad_far_side
`default_nettype wire

// [tb/gpio_pin_control_tb_top.sv]
// Self-checking bench for the pin control block over AXI4-Lite.
// Assumes the pad model in pad_far_side and a 40 MHz sys_clk.
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_control_tb_top;
    typedef struct {logic [31:0] wr; logic [31:0] rd; logic [3:0] pins;} row_t;
    typedef struct {logic [31:0] cfg; logic agg; logic from; int nWake; int nIrq;} edge_t;
    logic        sys_clk  = 1'b0;
    logic        rst      = 1'b1;
    logic        wdRst    = 1'b0;
    logic [3:0]  awaddr   = 4'h0;
    logic        awvalid  = 1'b0;
    logic [31:0] wdata    = 32'h0;
    logic        wvalid   = 1'b0;
    logic        bready   = 1'b0;
    logic [3:0]  araddr   = 4'h0;
    logic        arvalid  = 1'b0;
    logic        rready   = 1'b0;
    logic        aggEn    = 1'b0;
    logic        extLevel = 1'b0;
    logic        clkEn    = 1'b1;
    logic        extDrive = 1'b1;
    wire logic   awready, wready, bvalid, arready, rvalid, padIn, padOut, padOe;
    wire logic   pullUp, pullDown, pinIrq, ringWake, altIn;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    int          n_errors = 0;
    int          checked  = 0;
    int          wakes    = 0;
    int          irqs     = 0;
    logic [31:0] d;
    logic [1:0]  r;
    row_t        rows [15] = '{
        '{32'h0003_0200, 32'h0001_0200, 4'h3}, '{32'h0000_0201, 32'h0000_0201, 4'hb},
        '{32'h0000_0a02, 32'h0000_0a02, 4'h7}, '{32'h0000_0303, 32'h0000_0303, 4'h0},
        '{32'h0000_1000, 32'h0000_1000, 4'h3}, '{32'h0000_1800, 32'h0000_1800, 4'h2},
        '{32'h0000_2200, 32'h0000_2200, 4'h2}, '{32'h0000_2a00, 32'h0000_2a00, 4'h3},
        '{32'h0000_3200, 32'h0000_3200, 4'h0}, '{32'h0000_1900, 32'h0000_1900, 4'h2},
        '{32'hffff_ffff, 32'h0001_3bf3, 4'h0}, '{32'h0000_0010, 32'h0000_0010, 4'h0},
        '{32'h0000_0050, 32'h0000_0050, 4'h0}, '{32'h0000_0060, 32'h0000_0060, 4'h0},
        '{32'h0000_0070, 32'h0000_0070, 4'h0}};
    edge_t       edges [10] = '{
        '{32'h0000_00d0, 1'b1, 1'b0, 1, 1}, '{32'h0000_00d0, 1'b1, 1'b1, 0, 0},
        '{32'h0000_00e0, 1'b1, 1'b1, 1, 1}, '{32'h0000_00f0, 1'b1, 1'b0, 1, 1},
        '{32'h0000_00f0, 1'b1, 1'b1, 1, 1}, '{32'h0000_0090, 1'b1, 1'b0, 0, -1},
        '{32'h0000_0050, 1'b1, 1'b0, 0, 0}, '{32'h0000_00d0, 1'b0, 1'b0, 0, -1},
        '{32'h0000_38d0, 1'b1, 1'b1, 1, -1}, '{32'h0000_38d0, 1'b1, 1'b0, 0, -1}};

    always #12.5 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        if (ringWake === 1'b1) wakes++;
        if (pinIrq === 1'b1) irqs++;
    end

    gpio_pin_control #(.SYSTEM_RESET_ONLY(1'b0)) i_dut (
        .sys_clk(sys_clk), .rst(rst), .watchdogDrivenReset(wdRst), .clkEn(clkEn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .padIn(padIn), .padOut(padOut),
        .padOe(padOe), .pullUpEn(pullUp), .pullDownEn(pullDown), .altOut(3'b001),
        .altOe(3'b011), .altIn(altIn), .aggIrqEnable(aggEn), .ringStopped(1'b1),
        .pinIrq(pinIrq), .ringWake(ringWake));

    pad_far_side i_pad (
        .sys_clk(sys_clk), .padOut(padOut), .padOe(padOe), .pullUpEn(pullUp),
        .pullDownEn(pullDown), .extDrive(extDrive), .extLevel(extLevel), .padIn(padIn));

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic axiWrite(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        rs = bresp;
        bready <= 1'b0;
    endtask : axiWrite

    task automatic axiRead(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : axiRead

    task automatic levelTry(input logic [31:0] cfg, input logic lvl, input logic expIrq);
        @(posedge sys_clk);
        extLevel <= lvl;
        axiWrite(4'h0, cfg, r);
        repeat (4) @(posedge sys_clk);
        check({31'h0, pinIrq}, {31'h0, expIrq}, "level irq");
        check({31'h0, altIn}, {31'h0, (cfg[13:12] != 2'h0) & (lvl ^ cfg[11])}, "alt in");
        axiRead(4'h0, d, r);
        check({31'h0, d[24]}, {31'h0, lvl}, "pad input bit");
    endtask : levelTry

    task automatic stop_test;
        $display("Comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test

    initial begin
        #(25.0 * 20000);
        n_errors++;
        $display("BAD %0t watchdog expired", $time);
        stop_test();
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        axiRead(4'h0, d, r);
        check(d & 32'hfeff_ffff, 32'h0, "reset word");
        foreach (rows[i]) begin
            axiWrite(4'h0, rows[i].wr, r);
            repeat (3) @(posedge sys_clk);
            check({pullUp, pullDown, padOe, padOe & padOut}, rows[i].pins, "pins");
            axiRead(4'h0, d, r);
            check(d & 32'hfeff_ffff, rows[i].rd, "readback");
        end
        axiWrite(4'h8, 32'hffff_ffff, r);
        check(r, gpio_pin_pkg::RESP_SLVERR, "unmapped write");
        axiRead(4'h8, d, r);
        check(r, gpio_pin_pkg::RESP_SLVERR, "unmapped read");
        levelTry(32'h0000_0010, 1'b1, 1'b1);
        levelTry(32'h0000_0000, 1'b1, 1'b0);
        levelTry(32'h0000_0000, 1'b0, 1'b1);
        levelTry(32'h0000_3810, 1'b1, 1'b0);
        levelTry(32'h0000_1010, 1'b1, 1'b1);
        foreach (edges[i]) begin
            @(posedge sys_clk);
            aggEn <= edges[i].agg;
            extLevel <= edges[i].from;
            axiWrite(4'h0, edges[i].cfg, r);
            repeat (4) @(posedge sys_clk);
            @(negedge sys_clk);
            wakes = 0;
            irqs = 0;
            @(posedge sys_clk);
            extLevel <= ~edges[i].from;
            repeat (8) @(posedge sys_clk);
            check(wakes, edges[i].nWake, "wake count");
            if (edges[i].nIrq >= 0) check(irqs, edges[i].nIrq, "edge irq count");
        end
        extDrive <= 1'b0;
        axiWrite(4'h0, 32'h0000_0001, r);
        repeat (3) @(posedge sys_clk);
        axiRead(4'h0, d, r);
        check({31'h0, d[24]}, 32'h1, "pulled up pad");
        axiWrite(4'h0, 32'h0000_0002, r);
        repeat (3) @(posedge sys_clk);
        axiRead(4'h0, d, r);
        check({31'h0, d[24]}, 32'h0, "pulled down pad");
        extDrive <= 1'b1;
        axiRead(4'h4, d, r);
        check(d, 32'h1, "wake latch set");
        axiWrite(4'h4, 32'h1, r);
        axiRead(4'h4, d, r);
        check(d, 32'h0, "wake latch clear");
        extLevel <= 1'b1;
        axiWrite(4'h0, 32'h0000_0010, r);
        repeat (3) @(posedge sys_clk);
        extLevel <= 1'b0;
        clkEn <= 1'b0;
        repeat (4) @(posedge sys_clk);
        check({31'h0, pinIrq}, 32'h1, "frozen irq");
        clkEn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check({31'h0, pinIrq}, 32'h0, "irq after enable");
        axiWrite(4'h0, 32'h0000_1a00, r);
        @(posedge sys_clk);
        wdRst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        wdRst <= 1'b0;
        axiRead(4'h0, d, r);
        check(d & 32'hfeff_ffff, 32'h0, "watchdog reset word");
        stop_test();
    end
endmodule : gpio_pin_control_tb_top
`default_nettype wire
